// ===== rtl/vitc_transcoder.sv
// vertical interval time code transcoder with AHB-Lite register slave
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`include "vitc_cfg.svh"
`default_nettype none
module vitc_transcoder (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// interrupt
	output logic             irq,
	// input video
	input  wire logic        in_field_start,
	input  wire logic        in_is_sd,
	input  wire logic        in_rate_2398,
	input  wire logic        in_hd_1080p,
	input  wire logic [4:0]  in_line_num,
	input  wire logic        in_dig_valid,
	input  wire logic        in_ana_valid,
	input  wire logic [31:0] in_word,
	// output video
	input  wire logic        out_field_start,
	input  wire logic        out_frame_start,
	input  wire logic        out_is_sd,
	input  wire logic        out_line_start,
	input  wire logic [4:0]  out_line_num,
	output logic             ins_dig_valid,
	output logic             ins_ana_valid,
	output logic      [4:0]  ins_line,
	output logic      [31:0] ins_word
);
	// ==========================================================
	// line qualification
	function automatic logic line_ok(input logic [4:0] ln, input logic [4:0] fixed, input logic dig);
		logic form_ok;
		form_ok = dig || (ln >= `VITC_ANA_FIRST);
		if (fixed == `VITC_LINE_AUTO)
			line_ok = form_ok && (ln >= `VITC_AUTO_FIRST) && (ln <= `VITC_AUTO_LAST);
		else
			line_ok = form_ok && (ln == fixed) && (ln >= `VITC_LINE_MIN) && (ln <= `VITC_LINE_MAX);
	endfunction

	// ==========================================================
	// registers and state
	logic [31:0]           ctrl_r;
	logic [`VITC_IRQ_W-1:0] irq_stat_r;
	logic [`VITC_IRQ_W-1:0] irq_mask_r;
	vitc_pkg::src_sel_t    src_act_r;
	vitc_pkg::line_t       in_line_act_r;
	vitc_pkg::out_sel_t    out_sel_act_r;
	vitc_pkg::line_t       out_line_act_r;
	vitc_pkg::enc_t        enc_r;
	logic                  dig_pres_r, ana_pres_r, unsup_r;
	vitc_pkg::line_t       dig_ln_r, ana_ln_r, dig_found_ln_r, ana_found_ln_r;
	logic                  dig_seen_r, ana_seen_r;
	vitc_pkg::tc_word_t    dig_word_r, ana_word_r;
	logic                  dp_wr_r;
	logic [7:0]            dp_addr_r;
	logic [31:0]           hrdata_r;
	logic                  ins_dig_r, ins_ana_r;
	vitc_pkg::line_t       ins_line_r;
	vitc_pkg::tc_word_t    ins_word_r;

	vitc_word_if wif ();

	vitc_word_store u_store (
		.hclk    (hclk),
		.hresetn (hresetn),
		.p       (wif.store)
	);

	// ==========================================================
	// input detection
	wire unsup   = in_rate_2398 && in_hd_1080p;
	wire acc_dig = in_dig_valid && !unsup && line_ok(in_line_num, in_line_act_r, 1'b1);
	wire acc_ana = in_ana_valid && !unsup && in_is_sd && line_ok(in_line_num, in_line_act_r, 1'b0);
	wire new_dig = acc_dig && !dig_seen_r;
	wire new_ana = acc_ana && !ana_seen_r;

	// source choice over the field just ended, with its own setting
	wire src_auto = (src_act_r == vitc_pkg::SRC_AUTO);
	wire use_dig  = dig_seen_r && (src_auto || src_act_r == vitc_pkg::SRC_DIG);
	wire use_ana  = !use_dig && ana_seen_r && (src_auto || src_act_r == vitc_pkg::SRC_ANA);
	wire vitc_pkg::enc_t enc_nxt = use_dig ? vitc_pkg::ENC_DIG :
		(use_ana ? vitc_pkg::ENC_ANA : vitc_pkg::ENC_UNAVAIL);

	// same-rate words cross once per field; rate change is absorbed by the store
	assign wif.wr    = in_field_start && (use_dig || use_ana);
	assign wif.wdata = use_dig ? dig_word_r : ana_word_r;
	assign wif.rd    = out_frame_start;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dig_seen_r <= 1'b0;
			ana_seen_r <= 1'b0;
			dig_word_r <= 32'h0000_0000;
			ana_word_r <= 32'h0000_0000;
			dig_ln_r   <= 5'h00;
			ana_ln_r   <= 5'h00;
		end else if (in_field_start) begin
			dig_seen_r <= acc_dig;
			ana_seen_r <= acc_ana;
			dig_word_r <= in_word;
			ana_word_r <= in_word;
			dig_ln_r   <= in_line_num;
			ana_ln_r   <= in_line_num;
		end else begin
			if (new_dig) begin
				dig_seen_r <= 1'b1;
				dig_word_r <= in_word;
				dig_ln_r   <= in_line_num;
			end
			if (new_ana) begin
				ana_seen_r <= 1'b1;
				ana_word_r <= in_word;
				ana_ln_r   <= in_line_num;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enc_r          <= vitc_pkg::ENC_UNAVAIL;
			dig_pres_r     <= 1'b0;
			ana_pres_r     <= 1'b0;
			unsup_r        <= 1'b0;
			dig_found_ln_r <= 5'h00;
			ana_found_ln_r <= 5'h00;
		end else if (in_field_start) begin
			enc_r          <= enc_nxt;
			dig_pres_r     <= dig_seen_r;
			ana_pres_r     <= ana_seen_r;
			unsup_r        <= unsup;
			dig_found_ln_r <= dig_seen_r ? dig_ln_r : 5'h00;
			ana_found_ln_r <= ana_seen_r ? ana_ln_r : 5'h00;
		end
	end

	// ==========================================================
	// settings adopted at field boundaries only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_act_r      <= vitc_pkg::SRC_AUTO;
			in_line_act_r  <= `VITC_LINE_AUTO;
			out_sel_act_r  <= vitc_pkg::OUT_DIG;
			out_line_act_r <= `VITC_LINE_AUTO;
		end else begin
			if (in_field_start) begin
				src_act_r     <= vitc_pkg::src_sel_t'(ctrl_r[`VITC_CTRL_SRC]);
				in_line_act_r <= ctrl_r[`VITC_CTRL_INLINE];
			end
			if (out_field_start) begin
				out_sel_act_r  <= vitc_pkg::out_sel_t'(ctrl_r[`VITC_CTRL_OUTSEL]);
				out_line_act_r <= ctrl_r[`VITC_CTRL_OUTLINE];
			end
		end
	end

	// ==========================================================
	// output insertion
	wire out_line_valid = (out_line_act_r >= `VITC_LINE_MIN) && (out_line_act_r <= `VITC_LINE_MAX);
	wire vitc_pkg::line_t tgt_line = out_line_valid ? out_line_act_r : `VITC_OUT_DEFAULT;
	wire hit      = out_line_start && (out_line_num == tgt_line) && wif.have;
	wire dig_nxt  = hit && (out_sel_act_r == vitc_pkg::OUT_DIG);
	wire ana_nxt  = hit && (out_sel_act_r == vitc_pkg::OUT_ANA) && out_is_sd;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ins_dig_r  <= 1'b0;
			ins_ana_r  <= 1'b0;
			ins_line_r <= `VITC_OUT_DEFAULT;
			ins_word_r <= 32'h0000_0000;
		end else begin
			ins_dig_r <= dig_nxt;
			ins_ana_r <= ana_nxt;
			if (hit) begin
				ins_line_r <= tgt_line;
				ins_word_r <= wif.rdata;
			end
		end
	end

	assign ins_dig_valid = ins_dig_r;
	assign ins_ana_valid = ins_ana_r;
	assign ins_line      = ins_line_r;
	assign ins_word      = ins_word_r;

	// ==========================================================
	// AHB-Lite slave, zero wait states, read data latched in address phase
	wire        ap_valid = hsel && htrans[1] && hready;
	wire [7:0]  ap_addr  = haddr[7:0];
	wire        hi_zero  = (haddr[31:8] == 24'h00_0000);
	wire [31:0] status_w = {15'h0000, unsup_r, 2'h0, ana_found_ln_r, dig_found_ln_r, ana_pres_r, dig_pres_r, enc_r};
	wire [31:0] rd_mux   = !hi_zero ? 32'h0000_0000 :
		(ap_addr == `VITC_OFF_CTRL)     ? ctrl_r :
		(ap_addr == `VITC_OFF_STATUS)   ? status_w :
		(ap_addr == `VITC_OFF_IRQ_STAT) ? {29'h0000_0000, irq_stat_r} :
		(ap_addr == `VITC_OFF_IRQ_MASK) ? {29'h0000_0000, irq_mask_r} :
		(ap_addr == `VITC_OFF_WORD)     ? wif.rdata : 32'h0000_0000;
	wire        wr_ctrl  = dp_wr_r && (dp_addr_r == `VITC_OFF_CTRL);
	wire        wr_stat  = dp_wr_r && (dp_addr_r == `VITC_OFF_IRQ_STAT);
	wire        wr_mask  = dp_wr_r && (dp_addr_r == `VITC_OFF_IRQ_MASK);
	wire [`VITC_IRQ_W-1:0] clr_w = wr_stat ? hwdata[`VITC_IRQ_W-1:0] : 3'h0;
	wire [`VITC_IRQ_W-1:0] ev_w  = {wif.rep, wif.drop, in_field_start && (enc_nxt != enc_r)};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_r   <= 1'b0;
			dp_addr_r <= 8'h00;
			hrdata_r  <= 32'h0000_0000;
		end else begin
			dp_wr_r   <= ap_valid && hwrite && hi_zero;
			dp_addr_r <= ap_addr;
			if (ap_valid && !hwrite)
				hrdata_r <= rd_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r     <= `VITC_CTRL_RST;
			irq_mask_r <= 3'h0;
			irq_stat_r <= 3'h0;
		end else begin
			if (wr_ctrl)
				ctrl_r <= {17'h0_0000, hwdata[14:0]};
			if (wr_mask)
				irq_mask_r <= hwdata[`VITC_IRQ_W-1:0];
			// a new event wins over a clear in the same cycle
			irq_stat_r <= (irq_stat_r & ~clr_w) | ev_w;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;
	assign irq       = |(irq_stat_r & irq_mask_r);

	// ==========================================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	none_quiet_a: assert property (out_sel_act_r == vitc_pkg::OUT_NONE |=> !ins_dig_valid && !ins_ana_valid)
		else $error("time code inserted with output set to none");
	ana_sd_out_a: assert property (ana_nxt |-> out_is_sd ##1 ins_ana_valid && !ins_dig_valid)
		else $error("analog time code toward HD output");
	ins_line_a: assert property (hit |=> ins_line == $past(out_line_num)
		&& ins_line >= `VITC_LINE_MIN && ins_line <= `VITC_LINE_MAX)
		else $error("insertion on wrong line");
	default_line_a: assert property (hit && out_line_act_r == `VITC_LINE_AUTO
		|=> ins_line == `VITC_OUT_DEFAULT)
		else $error("default insertion line not used");
	unavail_a: assert property (in_field_start && !dig_seen_r && !ana_seen_r |=> enc_r == vitc_pkg::ENC_UNAVAIL)
		else $error("status not unavailable when nothing found");
	auto_dig_a: assert property (in_field_start && src_auto && dig_seen_r |=> enc_r == vitc_pkg::ENC_DIG && dig_pres_r)
		else $error("automatic status missed digital time code");
	src_hold_a: assert property (!in_field_start |=> $stable(src_act_r) && $stable(in_line_act_r))
		else $error("input setting changed inside a field");
	out_hold_a: assert property (!out_field_start
		|=> $stable(out_sel_act_r) && $stable(out_line_act_r))
		else $error("output setting changed inside a field");
	fixed_line_a: assert property (acc_dig && in_line_act_r != `VITC_LINE_AUTO
		|-> in_line_num == in_line_act_r)
		else $error("digital time code taken off the fixed line");
	fixed_src_a: assert property (in_field_start && src_act_r == vitc_pkg::SRC_ANA
		|=> enc_r != vitc_pkg::ENC_DIG)
		else $error("digital reported with analog source chosen");
	ana_hd_a: assert property (hit && out_sel_act_r == vitc_pkg::OUT_ANA && !out_is_sd
		|=> !ins_ana_valid)
		else $error("analog time code inserted into HD output");
	drop_flag_a: assert property (wif.drop |=> irq_stat_r[`VITC_IRQ_DROP])
		else $error("dropped word not flagged");
	rep_flag_a: assert property (wif.rep |=> irq_stat_r[`VITC_IRQ_REP])
		else $error("repeated word not flagged");
	ana_line_a: assert property (acc_ana |-> in_is_sd && in_line_num >= `VITC_ANA_FIRST)
		else $error("analog accepted on digital-only line or HD");
	auto_range_a: assert property (acc_dig && in_line_act_r == `VITC_LINE_AUTO
		|-> in_line_num >= `VITC_AUTO_FIRST && in_line_num <= `VITC_AUTO_LAST)
		else $error("automatic scan outside its lines");
	unsup_block_a: assert property (unsup |-> !acc_dig && !acc_ana)
		else $error("time code taken from 1080p/sf 23.98 input");
	word_pass_a: assert property (in_field_start && use_dig
		|=> wif.have && wif.rdata == $past(dig_word_r))
		else $error("digital word not carried to store");
endmodule
`default_nettype wire

// ===== rtl/vitc_cfg.svh
// constants for the vertical interval time code transcoder
`ifndef VITC_CFG_SVH
`define VITC_CFG_SVH

// register byte offsets
`define VITC_OFF_CTRL      8'h00
`define VITC_OFF_STATUS    8'h04
`define VITC_OFF_IRQ_STAT  8'h08
`define VITC_OFF_IRQ_MASK  8'h0C
`define VITC_OFF_WORD      8'h10

// control fields
`define VITC_CTRL_SRC      1:0
`define VITC_CTRL_INLINE   6:2
`define VITC_CTRL_OUTSEL   9:8
`define VITC_CTRL_OUTLINE  14:10
`define VITC_CTRL_RST      32'h0000_0100

// status fields
`define VITC_ST_ENC        1:0
`define VITC_ST_DIG        2
`define VITC_ST_ANA        3
`define VITC_ST_DIGLN      8:4
`define VITC_ST_ANALN      13:9
`define VITC_ST_UNSUP      16

// interrupt bits
`define VITC_IRQ_W         3
`define VITC_IRQ_ENC       0
`define VITC_IRQ_DROP      1
`define VITC_IRQ_REP       2

// video line numbers
`define VITC_LINE_AUTO     5'h00
`define VITC_LINE_MIN      5'h06
`define VITC_LINE_MAX      5'h16
`define VITC_AUTO_FIRST    5'h09
`define VITC_AUTO_LAST     5'h13
`define VITC_ANA_FIRST     5'h0B
`define VITC_OUT_DEFAULT   5'h09

`endif

// ===== rtl/vitc_pkg.sv
// types of the vertical interval time code transcoder
`default_nettype none
package vitc_pkg;
	typedef enum logic [1:0] {SRC_AUTO = 2'h0, SRC_DIG = 2'h1, SRC_ANA = 2'h2} src_sel_t;
	typedef enum logic [1:0] {OUT_NONE = 2'h0, OUT_DIG = 2'h1, OUT_ANA = 2'h2} out_sel_t;
	typedef enum logic [1:0] {ENC_UNAVAIL = 2'h0, ENC_DIG = 2'h1, ENC_ANA = 2'h3} enc_t;
	typedef logic [4:0]  line_t;
	typedef logic [31:0] tc_word_t;
endpackage
`default_nettype wire

// ===== rtl/vitc_word_if.sv
// time code word hand-off between transcoder and word store
`default_nettype none
interface vitc_word_if;
	logic              wr;
	vitc_pkg::tc_word_t wdata;
	logic              rd;
	vitc_pkg::tc_word_t rdata;
	logic              have;
	logic              fresh;
	logic              drop;
	logic              rep;
	modport user  (output wr, wdata, rd, input rdata, have, fresh, drop, rep);
	modport store (input wr, wdata, rd, output rdata, have, fresh, drop, rep);
endinterface
`default_nettype wire

// ===== rtl/vitc_word_store.sv
// single-word time code store, written per input field, read per output frame
`default_nettype none
module vitc_word_store (
	// clock and reset
	input  wire logic   hclk,
	input  wire logic   hresetn,
	// word port
	vitc_word_if.store  p
);
	vitc_pkg::tc_word_t word_r;
	logic               have_r;
	logic               fresh_r;

	assign p.rdata = word_r;
	assign p.have  = have_r;
	assign p.fresh = fresh_r;
	// a word overwritten before any output frame took it is lost
	assign p.drop  = p.wr && fresh_r && !p.rd;
	// an output frame that finds no new word sends the old one again
	assign p.rep   = p.rd && have_r && !fresh_r && !p.wr;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_r  <= 32'h0000_0000;
			have_r  <= 1'b0;
			fresh_r <= 1'b0;
		end else begin
			if (p.wr) begin
				word_r <= p.wdata;
				have_r <= 1'b1;
			end
			// a write in the read cycle stays fresh for the next frame
			fresh_r <= p.wr || (fresh_r && !p.rd);
		end
	end
endmodule
`default_nettype wire

// ===== testbench/vitc_video_model.sv
// video stream model: input fields with time code words, output frames and lines
`default_nettype none
module vitc_video_model (
	// clock
	input  wire logic   hclk,
	// input video
	output logic        in_field_start,
	output logic [4:0]  in_line_num,
	output logic        in_dig_valid,
	output logic        in_ana_valid,
	output logic [31:0] in_word,
	// output video
	output logic        out_field_start,
	output logic        out_frame_start,
	output logic        out_line_start,
	output logic [4:0]  out_line_num
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{in_field_start, in_dig_valid, in_ana_valid} = 3'h0;
		{out_field_start, out_frame_start, out_line_start} = 3'h0;
		in_line_num = 5'h00;
		out_line_num = 5'h00;
		in_word = 32'h0;
	end
	// ==========
	// input side
	task automatic in_fs();
		@(posedge hclk);
		in_field_start <= 1'h1;
		@(posedge hclk);
		in_field_start <= 1'h0;
	endtask
	task automatic in_tc(input logic a, input logic [4:0] ln, input logic [31:0] w);
		@(posedge hclk);
		in_dig_valid <= !a;
		in_ana_valid <= a;
		in_line_num <= ln;
		in_word <= w;
		@(posedge hclk);
		in_dig_valid <= 1'h0;
		in_ana_valid <= 1'h0;
		// no stale word or line once the strobe is gone
		in_word <= ~w;
		in_line_num <= ln + 5'h01;
	endtask
	// ==========
	// output side, one frame sample then the target line
	task automatic out_fr(input logic fld, input logic [4:0] ln);
		@(posedge hclk);
		out_field_start <= fld;
		out_frame_start <= 1'h1;
		@(posedge hclk);
		out_field_start <= 1'h0;
		out_frame_start <= 1'h0;
		out_line_start <= 1'h1;
		out_line_num <= ln;
		@(posedge hclk);
		out_line_start <= 1'h0;
		out_line_num <= ln + 5'h01;
	endtask
endmodule
`default_nettype wire

// ===== testbench/vitc_timecode_transcoder_tb_top.sv
// self-checking bench of the time code transcoder
`include "vitc_cfg.svh"
`default_nettype none
module vitc_timecode_transcoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, dp, ap;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, in_word, ins_word, x, w0, w1;
	logic        in_field_start, in_is_sd, in_rate_2398, in_hd_1080p, in_dig_valid, in_ana_valid;
	logic        out_field_start, out_frame_start, out_is_sd, out_line_start, ins_dig_valid, ins_ana_valid;
	logic [4:0]  in_line_num, out_line_num, ins_line;
	logic [14:0] t;
	int          miscompares, cmp_count, seed, i;
	// {fixed line, analog, sd, line, expected encoding}
	localparam logic [14:0] det_tbl [12] = '{15'h0025, 15'h004D, 15'h001C, 15'h0050, 15'h2851, 15'h0C19,
		15'h01B3, 15'h01A8, 15'h0130, 15'h2DDB, 15'h0020, 15'h13A4};
	// {output form, output line, sd, hit line, digital, analog}
	localparam logic [14:0] out_tbl [7] = '{15'h2026, 15'h365A, 15'h2526, 15'h269A, 15'h09A4, 15'h4B2C, 15'h4BAD};

	vitc_transcoder u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .in_field_start, .in_is_sd, .in_rate_2398,
		.in_hd_1080p, .in_line_num, .in_dig_valid, .in_ana_valid, .in_word, .out_field_start,
		.out_frame_start, .out_is_sd, .out_line_start, .out_line_num, .ins_dig_valid, .ins_ana_valid,
		.ins_line, .ins_word);
	vitc_video_model u_vid (.hclk, .in_field_start, .in_line_num, .in_dig_valid, .in_ana_valid, .in_word,
		.out_field_start, .out_frame_start, .out_line_start, .out_line_num);

	initial begin
		hclk = 1'h0;
		forever #20 hclk = ~hclk;
	end
	// ==========
	// checks and bus cycles
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_reg({31'h0, got}, {31'h0, exp});
	endtask
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'h1 && n < 40);
		if (hreadyout !== 1'h1) begin
			miscompares++;
			summarize();
		end
	endtask
	// one idle cycle after each transfer so a read never trails a write
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_rdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		x = hrdata;
		chk_bit(hresp, 1'h0);
		@(posedge hclk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		ahb(1'h0, a, 32'h0);
		chk_reg(x & m, e);
	endtask
	task automatic tfield(input logic a, input logic [4:0] ln, input logic [31:0] w);
		u_vid.in_fs();
		u_vid.in_tc(a, ln, w);
		u_vid.in_fs();
	endtask
	task automatic ochk(input logic dv, input logic av, input logic [4:0] ln, input logic [31:0] w);
		#1;
		chk_bit(ins_dig_valid, dv);
		chk_bit(ins_ana_valid, av);
		if (dv | av) begin
			chk_reg({27'h0, ins_line}, {27'h0, ln});
			chk_reg(ins_word, w);
		end
		@(posedge hclk);
	endtask
	function automatic logic [31:0] mk_ctrl(input logic [1:0] s, input logic [4:0] il, input logic [1:0] os,
		input logic [4:0] ol);
		return {17'h0, ol, os, 1'h0, il, s};
	endfunction
	function automatic logic [31:0] exp_st(input logic [1:0] e, input logic d, input logic a, input logic u,
		input logic [4:0] ln);
		return {15'h0, u, 2'h0, a ? ln : 5'h00, d ? ln : 5'h00, a, d, e};
	endfunction
	// ==========
	// main sequence
	initial begin
		seed = 12;
		{hsel, hwrite, in_is_sd, in_rate_2398, in_hd_1080p, out_is_sd} = 6'h0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		hresetn = 1'h0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		chk_reg({27'h0, ins_line}, {27'h0, `VITC_OUT_DEFAULT});
		chk_bit(irq, 1'h0);
		rdc(`VITC_OFF_CTRL, 32'hFFFF_FFFF, `VITC_CTRL_RST);
		rdc(`VITC_OFF_STATUS, 32'h0001_000F, 32'h0);
		rdc(`VITC_OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0);
		ahb(1'h1, 8'h40, 32'hFFFF_FFFF);
		rdc(8'h40, 32'hFFFF_FFFF, 32'h0);
		$display("test reset done");
		for (i = 0; i < 12; i++) begin
			t = det_tbl[i];
			dp = t[1:0] == 2'h1;
			ap = t[1:0] == 2'h3;
			in_is_sd <= t[7];
			ahb(1'h1, `VITC_OFF_CTRL, mk_ctrl(2'h0, t[13:9], 2'h1, 5'h00));
			tfield(t[8], t[6:2], $random(seed));
			rdc(`VITC_OFF_STATUS, {15'h0, 1'h1, 2'h0, {5{ap}}, {5{dp}}, 4'hF}, exp_st(t[1:0], dp, ap, 1'h0, t[6:2]));
		end
		$display("test detection done");
		in_is_sd <= 1'h1;
		w0 = $random(seed);
		w1 = $random(seed);
		for (i = 0; i < 3; i++) begin
			ahb(1'h1, `VITC_OFF_CTRL, mk_ctrl(i[1:0], 5'h00, 2'h1, 5'h00));
			u_vid.in_fs();
			u_vid.in_tc(1'h0, 5'h09, w0);
			u_vid.in_tc(1'h1, 5'h0C, w1);
			u_vid.in_fs();
			rdc(`VITC_OFF_STATUS, 32'h0001_000F, exp_st(i == 2 ? 2'h3 : 2'h1, 1'h1, 1'h1, 1'h0, 5'h00));
			rdc(`VITC_OFF_WORD, 32'hFFFF_FFFF, i == 2 ? w1 : w0);
		end
		in_rate_2398 <= 1'h1;
		in_hd_1080p <= 1'h1;
		ahb(1'h1, `VITC_OFF_CTRL, mk_ctrl(2'h0, 5'h00, 2'h1, 5'h00));
		tfield(1'h0, 5'h09, w1);
		rdc(`VITC_OFF_STATUS, 32'h0001_000F, exp_st(2'h0, 1'h0, 1'h0, 1'h1, 5'h00));
		in_hd_1080p <= 1'h0;
		tfield(1'h0, 5'h09, w0);
		$display("test source done");
		for (i = 0; i < 7; i++) begin
			t = out_tbl[i];
			out_is_sd <= t[7];
			ahb(1'h1, `VITC_OFF_CTRL, mk_ctrl(2'h0, 5'h00, t[14:13], t[12:8]));
			u_vid.out_fr(1'h1, t[6:2]);
			ochk(t[1], t[0], t[6:2], w0);
		end
		ahb(1'h1, `VITC_OFF_CTRL, mk_ctrl(2'h0, 5'h00, 2'h0, 5'h00));
		u_vid.out_fr(1'h0, 5'h0B);
		ochk(1'h0, 1'h1, 5'h0B, w0);
		u_vid.out_fr(1'h1, 5'h0B);
		ochk(1'h0, 1'h0, 5'h0B, w0);
		$display("test output done");
		ahb(1'h1, `VITC_OFF_CTRL, mk_ctrl(2'h0, 5'h00, 2'h1, 5'h00));
		ahb(1'h1, `VITC_OFF_IRQ_MASK, 32'h6);
		rdc(`VITC_OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h6);
		w1 = $random(seed);
		tfield(1'h0, 5'h09, w1);
		ahb(1'h1, `VITC_OFF_IRQ_STAT, 32'h7);
		u_vid.out_fr(1'h1, 5'h09);
		ochk(1'h1, 1'h0, 5'h09, w1);
		rdc(`VITC_OFF_IRQ_STAT, 32'h6, 32'h0);
		u_vid.out_fr(1'h1, 5'h09);
		ochk(1'h1, 1'h0, 5'h09, w1);
		rdc(`VITC_OFF_IRQ_STAT, 32'h6, 32'h4);
		chk_bit(irq, 1'h1);
		ahb(1'h1, `VITC_OFF_IRQ_STAT, 32'h4);
		rdc(`VITC_OFF_IRQ_STAT, 32'h6, 32'h0);
		chk_bit(irq, 1'h0);
		in_rate_2398 <= 1'h0;
		tfield(1'h0, 5'h09, w0);
		w1 = $random(seed);
		tfield(1'h0, 5'h09, w1);
		u_vid.out_fr(1'h1, 5'h09);
		ochk(1'h1, 1'h0, 5'h09, w1);
		rdc(`VITC_OFF_IRQ_STAT, 32'h6, 32'h2);
		chk_bit(irq, 1'h1);
		ahb(1'h1, `VITC_OFF_IRQ_MASK, 32'h0);
		chk_bit(irq, 1'h0);
		$display("test rates done");
		summarize();
	end
endmodule
`default_nettype wire
